// ==== hdl/dual_timer_pkg.sv ====
// constants, register map and carrier types of the dual 8-bit timer/counter
package dual_timer_pkg;

	// ***************************************************************
	// register indices (byte address is four times the index)
	// ***************************************************************
	localparam logic [5:0] idx_lower_compare_value = 6'h10;
	localparam logic [5:0] idx_upper_compare_value = 6'h11;
	localparam logic [5:0] idx_lower_duty_value    = 6'h12;
	localparam logic [5:0] idx_upper_duty_value    = 6'h13;
	localparam logic [5:0] idx_operation_config    = 6'h14;
	localparam logic [5:0] idx_lower_count_value   = 6'h15;
	localparam logic [5:0] idx_upper_count_value   = 6'h16;
	localparam logic [5:0] idx_lower_timer_control = 6'h1a;
	localparam logic [5:0] idx_upper_timer_control = 6'h1b;

	// ***************************************************************
	// field positions and reset values
	// ***************************************************************
	localparam int         cfg_divider_chain_bit = 0;
	localparam int         cfg_slow_mode_bit     = 1;
	localparam logic [7:0] control_reset         = 8'h00;
	localparam logic [7:0] value_reset           = 8'h00;
	localparam logic [1:0] config_reset          = 2'h0;

	// ***************************************************************
	// clock select codes
	// ***************************************************************
	localparam logic [2:0] clk_div11_or_slow8 = 3'h0;
	localparam logic [2:0] clk_div7           = 3'h1;
	localparam logic [2:0] clk_div5           = 3'h2;
	localparam logic [2:0] clk_div3           = 3'h3;
	localparam logic [2:0] clk_slow           = 3'h4;
	localparam logic [2:0] clk_div1           = 3'h5;
	localparam logic [2:0] clk_fast           = 3'h6;
	localparam logic [2:0] clk_pin            = 3'h7;

	// ***************************************************************
	// mode codes
	// ***************************************************************
	localparam logic [2:0] mode_timer_event8  = 3'h0;
	localparam logic [2:0] mode_divider8      = 3'h1;
	localparam logic [2:0] mode_pwm8          = 3'h2;
	localparam logic [2:0] mode_reserved      = 3'h3;
	localparam logic [2:0] mode_timer_event16 = 3'h4;
	localparam logic [2:0] mode_warmup        = 3'h5;
	localparam logic [2:0] mode_pwm16         = 3'h6;
	localparam logic [2:0] mode_pulse_gen16   = 3'h7;

	// ***************************************************************
	// prescaler exponents
	// ***************************************************************
	localparam int prescale_width = 11;
	localparam int slow_div_width = 3;

	// control register layout
	typedef struct packed {
		logic       flipflop_init;
		logic [2:0] clock_select;
		logic       run_bit;
		logic [2:0] mode_field;
	} timer_control_type;

	// prescaled tick set
	typedef struct packed {
		logic div11;
		logic div7;
		logic div5;
		logic div3;
		logic div1;
		logic slow;
		logic slow8;
	} tick_set_type;

endpackage

// ==== hdl/timer_channel_counter.sv ====
// one 8-bit up-counter of a timer channel
`timescale 1ns/1ps
module timer_channel_counter (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       tick,
	input  wire logic       clear,
	output logic [7:0]      count_ff,
	output logic            wrap
);
	logic [7:0] nxt_count;

	// clear beats counting
	always_comb begin
		nxt_count = count_ff;
		if (clear) begin
			nxt_count = 8'h00;
		end else if (tick) begin
			nxt_count = count_ff + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= 8'h00;
		end else if (ce) begin
			count_ff <= nxt_count;
		end
	end

	// overflow into the cascaded channel
	assign wrap = tick & (count_ff == 8'hff);
endmodule // timer_channel_counter

// ==== hdl/dual_timer_counter.sv ====
// dual 8-bit timer/counter with APB register access and 16-bit cascade
`timescale 1ns/1ps
// What this block does
// [RQ1] clock select picks a prescaled fast, slow or pin source for counting
// [RQ2] mode field decodes timer, divider, PWM, reserved and 16-bit modes; code counts only in 8-bit timer/event, divider and 16-bit timer/event
// [RQ3] upper control register resets to all zeros, timer stopped
// [RQ4] software keeps mode, clock and flip-flop fixed while running
// [RQ5] stopping leaves other fields alone; starting may write them together
// [RQ6] 16-bit: lower mode 011, upper mode, lower clock, upper run and flip-flop
// [RQ7] upper counter clocks from cascade overflow in 16-bit modes
// [RQ8] software leaves compare and duty values alone while running
// [RQ9] normal operation allows only listed sources per mode
// [RQ10] slow operation allows only listed sources per mode
// [RQ11] fast oscillator in slow operation only for warm-up
// [RQ12] 8-bit compare 1..255, 8-bit duty 2..254
// [RQ13] 16-bit compare and duty values stay inside listed limits
// [RQ14] timer mode counts source ticks, match raises irq, clears, continues
// [RQ15] software keeps flip-flop bit zero in timer and event modes
// [RQ16] compare value is unbuffered and acts at once
// [RQ17] event mode counts pin falling edges, match raises irq and clears
// [RQ18] event input levels last at least two machine cycles
// [RQ19] each channel has control, compare and duty registers
// [RQ20] writing flip-flop bit loads output flip-flop; pin shows inverse
// [RQ21] run bit low stops and clears counter; start counts from zero
// [RQ22] timer irq period equals compare value times source period
module dual_timer_counter (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        slow_osc,
	input  wire logic        lower_counter_input,
	input  wire logic        upper_counter_input,
	output logic             lower_match_irq,
	output logic             upper_match_irq,
	output logic             lower_divider_out_pin_n,
	output logic             upper_divider_out_pin_n
);
	// ***************************************************************
	// register state
	// ***************************************************************
	dual_timer_pkg::timer_control_type lower_ctl_ff, nxt_lower_ctl;
	dual_timer_pkg::timer_control_type upper_ctl_ff, nxt_upper_ctl;
	logic [7:0]  lower_cmp_ff, nxt_lower_cmp, upper_cmp_ff, nxt_upper_cmp;
	logic [7:0]  lower_duty_ff, nxt_lower_duty, upper_duty_ff, nxt_upper_duty;
	logic [1:0]  config_ff, nxt_config;
	logic        lower_tff_ff, nxt_lower_tff, upper_tff_ff, nxt_upper_tff;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        err_ff, nxt_err;
	logic        lower_irq_ff, upper_irq_ff;

	// ***************************************************************
	// clock sources
	// ***************************************************************
	logic [10:0] pre_ff;
	logic [2:0]  slow_div_ff;
	logic [2:0]  slow_sync_ff, lower_sync_ff, upper_sync_ff;
	dual_timer_pkg::tick_set_type ticks;
	logic        slow_tick, lower_fall, upper_fall;
	logic        slow_sel;

	// second and third stages only feed edge detection
	assign slow_tick  = slow_sync_ff[1] & ~slow_sync_ff[2];
	assign lower_fall = ~lower_sync_ff[1] & lower_sync_ff[2]; // RQ17
	assign upper_fall = ~upper_sync_ff[1] & upper_sync_ff[2]; // RQ17
	assign slow_sel   = config_ff[dual_timer_pkg::cfg_divider_chain_bit] |
	                    config_ff[dual_timer_pkg::cfg_slow_mode_bit];

	// ticks of the fast and slow prescalers, fast oscillator being pclk
	assign ticks.div11 = &pre_ff[10:0];
	assign ticks.div7  = &pre_ff[6:0];
	assign ticks.div5  = &pre_ff[4:0];
	assign ticks.div3  = &pre_ff[2:0];
	assign ticks.div1  = pre_ff[0];
	assign ticks.slow  = slow_tick;
	assign ticks.slow8 = slow_tick & (&slow_div_ff);

	// source selection shared by both channels
	function automatic logic pick_source(input logic [2:0] sel, input logic pin_fall,
	                                     input dual_timer_pkg::tick_set_type t, input logic use_slow);
		logic r;
		r = 1'b0;
		case (sel)
			dual_timer_pkg::clk_div11_or_slow8: r = use_slow ? t.slow8 : t.div11; // RQ1
			dual_timer_pkg::clk_div7:           r = t.div7;
			dual_timer_pkg::clk_div5:           r = t.div5;
			dual_timer_pkg::clk_div3:           r = t.div3;
			dual_timer_pkg::clk_slow:           r = t.slow;
			dual_timer_pkg::clk_div1:           r = t.div1;
			dual_timer_pkg::clk_fast:           r = 1'b1;
			default:                            r = pin_fall;
		endcase
		return r;
	endfunction

	// prescalers and pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff        <= 11'h000;
			slow_div_ff   <= 3'h0;
			slow_sync_ff  <= 3'h0;
			lower_sync_ff <= 3'h0;
			upper_sync_ff <= 3'h0;
		end else if (ce) begin
			pre_ff        <= pre_ff + 11'h001;
			slow_div_ff   <= slow_tick ? slow_div_ff + 3'h1 : slow_div_ff;
			slow_sync_ff  <= {slow_sync_ff[1:0], slow_osc};
			lower_sync_ff <= {lower_sync_ff[1:0], lower_counter_input};
			upper_sync_ff <= {upper_sync_ff[1:0], upper_counter_input};
		end
	end

	// ***************************************************************
	// counting and cascade
	// ***************************************************************
	logic        cascade, lower_run, lower_counts, upper_counts;
	logic        lower_tick, upper_tick, lower_wrap;
	logic        lower_match8, upper_match8, match16, lower_clear, upper_clear;
	logic [7:0]  lower_count, upper_count;

	// upper mode top bit joins both channels, run taken from upper
	assign cascade      = upper_ctl_ff.mode_field[2]; // RQ6
	assign lower_run    = cascade ? upper_ctl_ff.run_bit : lower_ctl_ff.run_bit; // RQ6
	assign lower_counts = cascade ? (upper_ctl_ff.mode_field == dual_timer_pkg::mode_timer_event16) :
	                      ((lower_ctl_ff.mode_field == dual_timer_pkg::mode_timer_event8) |
	                       (lower_ctl_ff.mode_field == dual_timer_pkg::mode_divider8)); // RQ2
	assign upper_counts = (upper_ctl_ff.mode_field == dual_timer_pkg::mode_timer_event8) |
	                      (upper_ctl_ff.mode_field == dual_timer_pkg::mode_divider8); // RQ2
	assign lower_tick   = lower_run & lower_counts &
	                      pick_source(lower_ctl_ff.clock_select, lower_fall, ticks, slow_sel); // RQ14
	assign upper_tick   = cascade ? (lower_wrap & ~match16) : // RQ7
	                      (upper_ctl_ff.run_bit & upper_counts &
	                       pick_source(upper_ctl_ff.clock_select, upper_fall, ticks, slow_sel));

	// compare against live value, period is compare times source period
	assign lower_match8 = ~cascade & lower_tick & (lower_count + 8'h01 == lower_cmp_ff); // RQ16
	assign upper_match8 = ~cascade & upper_tick & (upper_count + 8'h01 == upper_cmp_ff); // RQ22
	assign match16      = cascade & lower_tick &
	                      ({upper_count, lower_count} + 16'h0001 == {upper_cmp_ff, lower_cmp_ff});
	assign lower_clear  = ~lower_run | lower_match8 | match16; // RQ21
	assign upper_clear  = ~upper_ctl_ff.run_bit | upper_match8 | match16; // RQ21

	timer_channel_counter u_lower (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.tick     (lower_tick),
		.clear    (lower_clear),
		.count_ff (lower_count),
		.wrap     (lower_wrap)
	);

	timer_channel_counter u_upper (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.tick     (upper_tick),
		.clear    (upper_clear),
		.count_ff (upper_count),
		.wrap     ()
	);

	// ***************************************************************
	// apb register file
	// ***************************************************************
	logic       wr_en, rd_setup, aligned;
	logic [5:0] idx;

	assign idx      = paddr[7:2];
	assign aligned  = (paddr[1:0] == 2'h0);
	assign wr_en    = ce & psel & penable & pwrite & pstrb[0] & ~err_ff;
	assign rd_setup = ce & psel & ~penable;
	assign pready   = psel & penable & ce;
	assign pslverr  = psel & penable & err_ff;
	assign prdata   = rdata_ff;

	// writes, read capture in setup, flip-flop load and toggle
	always_comb begin
		nxt_lower_ctl  = lower_ctl_ff;
		nxt_upper_ctl  = upper_ctl_ff;
		nxt_lower_cmp  = lower_cmp_ff;
		nxt_upper_cmp  = upper_cmp_ff;
		nxt_lower_duty = lower_duty_ff;
		nxt_upper_duty = upper_duty_ff;
		nxt_config     = config_ff;
		nxt_rdata      = rdata_ff;
		nxt_err        = err_ff;
		nxt_lower_tff  = lower_tff_ff;
		nxt_upper_tff  = upper_tff_ff;
		// divider mode toggles the output flip-flop on each match
		if (lower_match8 && lower_ctl_ff.mode_field == dual_timer_pkg::mode_divider8) begin
			nxt_lower_tff = ~lower_tff_ff;
		end
		if (upper_match8 && upper_ctl_ff.mode_field == dual_timer_pkg::mode_divider8) begin
			nxt_upper_tff = ~upper_tff_ff;
		end
		if (wr_en) begin
			if (idx == dual_timer_pkg::idx_lower_timer_control) begin
				nxt_lower_ctl = dual_timer_pkg::timer_control_type'(pwdata[7:0]); // RQ19
				nxt_lower_tff = pwdata[7]; // RQ20
			end else if (idx == dual_timer_pkg::idx_upper_timer_control) begin
				nxt_upper_ctl = dual_timer_pkg::timer_control_type'(pwdata[7:0]);
				nxt_upper_tff = pwdata[7]; // RQ20
			end else if (idx == dual_timer_pkg::idx_lower_compare_value) begin
				nxt_lower_cmp = pwdata[7:0]; // RQ16
			end else if (idx == dual_timer_pkg::idx_upper_compare_value) begin
				nxt_upper_cmp = pwdata[7:0]; // RQ16
			end else if (idx == dual_timer_pkg::idx_lower_duty_value) begin
				nxt_lower_duty = pwdata[7:0];
			end else if (idx == dual_timer_pkg::idx_upper_duty_value) begin
				nxt_upper_duty = pwdata[7:0];
			end else if (idx == dual_timer_pkg::idx_operation_config) begin
				nxt_config = pwdata[1:0];
			end
		end
		if (rd_setup) begin
			nxt_err   = 1'b0;
			nxt_rdata = 32'h0000_0000;
			if (!aligned) begin
				nxt_err = 1'b1;
			end else if (idx == dual_timer_pkg::idx_lower_timer_control) begin
				nxt_rdata = {24'h000000, lower_ctl_ff};
			end else if (idx == dual_timer_pkg::idx_upper_timer_control) begin
				nxt_rdata = {24'h000000, upper_ctl_ff};
			end else if (idx == dual_timer_pkg::idx_lower_compare_value) begin
				nxt_rdata = {24'h000000, lower_cmp_ff};
			end else if (idx == dual_timer_pkg::idx_upper_compare_value) begin
				nxt_rdata = {24'h000000, upper_cmp_ff};
			end else if (idx == dual_timer_pkg::idx_lower_duty_value) begin
				nxt_rdata = {24'h000000, lower_duty_ff};
			end else if (idx == dual_timer_pkg::idx_upper_duty_value) begin
				nxt_rdata = {24'h000000, upper_duty_ff};
			end else if (idx == dual_timer_pkg::idx_operation_config) begin
				nxt_rdata = {30'h00000000, config_ff};
			end else if (idx == dual_timer_pkg::idx_lower_count_value) begin
				nxt_rdata = {24'h000000, lower_count};
				nxt_err   = pwrite; // read only
			end else if (idx == dual_timer_pkg::idx_upper_count_value) begin
				nxt_rdata = {24'h000000, upper_count};
				nxt_err   = pwrite; // read only
			end else begin
				nxt_err = 1'b1; // unmapped
			end
		end
	end

	// register stage, everything zero after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_ctl_ff  <= dual_timer_pkg::timer_control_type'(dual_timer_pkg::control_reset);
			upper_ctl_ff  <= dual_timer_pkg::timer_control_type'(dual_timer_pkg::control_reset); // RQ3
			lower_cmp_ff  <= dual_timer_pkg::value_reset;
			upper_cmp_ff  <= dual_timer_pkg::value_reset;
			lower_duty_ff <= dual_timer_pkg::value_reset;
			upper_duty_ff <= dual_timer_pkg::value_reset;
			config_ff     <= dual_timer_pkg::config_reset;
			rdata_ff      <= 32'h0000_0000;
			err_ff        <= 1'b0;
			lower_tff_ff  <= 1'b0; // RQ20
			upper_tff_ff  <= 1'b0; // RQ20
			lower_irq_ff  <= 1'b0;
			upper_irq_ff  <= 1'b0;
		end else if (ce) begin
			lower_ctl_ff  <= nxt_lower_ctl;
			upper_ctl_ff  <= nxt_upper_ctl;
			lower_cmp_ff  <= nxt_lower_cmp;
			upper_cmp_ff  <= nxt_upper_cmp;
			lower_duty_ff <= nxt_lower_duty;
			upper_duty_ff <= nxt_upper_duty;
			config_ff     <= nxt_config;
			rdata_ff      <= nxt_rdata;
			err_ff        <= nxt_err;
			lower_tff_ff  <= nxt_lower_tff;
			upper_tff_ff  <= nxt_upper_tff;
			lower_irq_ff  <= lower_match8; // RQ14
			upper_irq_ff  <= upper_match8 | match16; // RQ17
		end
	end

	// divider output pins show the inverse of the flip-flops
	assign lower_match_irq         = lower_irq_ff;
	assign upper_match_irq         = upper_irq_ff;
	assign lower_divider_out_pin_n = ~lower_tff_ff; // RQ20
	assign upper_divider_out_pin_n = ~upper_tff_ff; // RQ20
endmodule // dual_timer_counter

// ==== testbench/dual_timer_counter_properties.sv ====
// port-level assertion checker of the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        lower_counter_input,
	input wire logic        lower_match_irq,
	input wire logic        upper_match_irq,
	input wire logic        lower_divider_out_pin_n,
	input wire logic        upper_divider_out_pin_n
);
	// ***************************************************************
	// shadow of accepted writes, irq spacing and pin edge age
	// ***************************************************************
	dual_timer_pkg::timer_control_type ctl_l_ff, ctl_u_ff;
	logic [7:0]  cmp_l_ff, cmp_u_ff, age_ff;
	logic [15:0] gap_ff, per;
	logic        seen_ff, pin_ff, wr, fast8, fast16, ev_l;
	// decoded conditions of the shadowed settings
	assign wr = psel && penable && pwrite && ce && pstrb[0] && pready && !pslverr;
	assign fast8 = ctl_u_ff.run_bit && ctl_u_ff.mode_field == 3'h0 && ctl_u_ff.clock_select == 3'h6;
	assign fast16 = ctl_u_ff.run_bit && ctl_u_ff.mode_field == 3'h4 && ctl_l_ff.clock_select == 3'h6;
	assign per = fast8 ? {8'h00, cmp_u_ff} : {cmp_u_ff, cmp_l_ff};
	assign ev_l = ctl_l_ff.run_bit && ctl_l_ff.clock_select == 3'h7 && ctl_l_ff.mode_field == 3'h0;
	// any accepted write restarts the spacing check, so a changed setting never trips it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_l_ff <= '0;
			ctl_u_ff <= '0;
			cmp_l_ff <= 8'h00;
			cmp_u_ff <= 8'h00;
			gap_ff <= 16'h0000;
			seen_ff <= 1'b0;
			pin_ff <= 1'b1;
			age_ff <= 8'hff;
		end else begin
			if (wr && paddr == 8'h68) ctl_l_ff <= pwdata[7:0];
			if (wr && paddr == 8'h6c) ctl_u_ff <= pwdata[7:0];
			if (wr && paddr == 8'h40) cmp_l_ff <= pwdata[7:0];
			if (wr && paddr == 8'h44) cmp_u_ff <= pwdata[7:0];
			gap_ff <= upper_match_irq ? 16'h0000 : gap_ff + 16'h0001;
			seen_ff <= !wr && ce && (fast8 || fast16) && (seen_ff || upper_match_irq);
			pin_ff <= lower_counter_input;
			age_ff <= (pin_ff && !lower_counter_input) ? 8'h00 : age_ff + {7'h00, age_ff != 8'hff};
		end
	end
	// ***************************************************************
	// assertions
	// ***************************************************************
	reset_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !upper_match_irq && !lower_match_irq && upper_divider_out_pin_n && lower_divider_out_pin_n)
		else $error("outputs not idle after reset");
	access_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && ce |-> pready) else $error("access phase without ready");
	unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && paddr == 8'h00 |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped read not refused");
	count_readonly_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && paddr == 8'h54 |-> pslverr) else $error("count write not refused");
	upper_ffload_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == 8'h6c && pwdata[2:0] == 3'h0 |=> ##[0:1] upper_divider_out_pin_n == !ctl_u_ff.flipflop_init)
		else $error("upper pin not inverse of loaded flip-flop");
	lower_ffload_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == 8'h68 && pwdata[2:0] == 3'h0 |=> ##[0:1] lower_divider_out_pin_n == !ctl_l_ff.flipflop_init)
		else $error("lower pin not inverse of loaded flip-flop");
	stopped_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl_u_ff.run_bit && !$past(ctl_u_ff.run_bit) |-> !upper_match_irq) else $error("irq while stopped");
	irq_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		upper_match_irq && seen_ff |-> gap_ff == per - 16'h0001) else $error("irq spacing differs from compare");
	event_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
		lower_match_irq && ev_l |-> age_ff <= 8'h0a) else $error("event irq without recent falling edge");
endmodule // dual_timer_counter_properties

// ==== testbench/dual_timer_counter_tb_top.sv ====
// self-checking testbench of the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_tb_top;
	typedef struct packed {logic [7:0] a; logic [3:0] s; logic [7:0] d; logic [31:0] r; logic we; logic re;} reg_row_type;
	typedef struct packed {logic [7:0] lc; logic [7:0] lv; logic [7:0] uc; logic [7:0] uv; logic [1:0] cfg;
		logic [1:0] sel; logic [15:0] gap;} gap_row_type;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slow_osc, pin_prev;
	logic        lower_counter_input, upper_counter_input, lower_match_irq, upper_match_irq, e;
	logic        lower_divider_out_pin_n, upper_divider_out_pin_n;
	logic [7:0]  paddr, uc_now, lc_now;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic [15:0] n;
	int          n_fail, num_checks, cycles, slow_cnt, n_irq_l, n_irq_u, il, iu;
	// register rows: address, strobe, write data, read back, write and read refusal
	reg_row_type regs [8] = '{'{8'h40, 4'h1, 8'ha5, 32'ha5, 0, 0}, '{8'h40, 4'h0, 8'h11, 32'ha5, 0, 0},
		'{8'h44, 4'h1, 8'h3c, 32'h3c, 0, 0}, '{8'h48, 4'h1, 8'h7e, 32'h7e, 0, 0}, '{8'h4c, 4'h1, 8'h81, 32'h81, 0, 0},
		'{8'h6c, 4'h1, 8'h83, 32'h83, 0, 0}, '{8'h54, 4'h1, 8'h12, 32'h0, 1, 0}, '{8'h00, 4'h1, 8'h12, 32'h0, 1, 1}};
	// spacing rows: lower ctl/cmp, upper ctl/cmp, config, watched event, cycles between events
	gap_row_type gaps [12] = '{'{8'h0, 8'h0, 8'h08, 8'h2, 2'h0, 2'h0, 16'd4096},
		'{8'h0, 8'h0, 8'h18, 8'h2, 2'h0, 2'h0, 16'd256}, '{8'h0, 8'h0, 8'h28, 8'h2, 2'h0, 2'h0, 16'd64},
		'{8'h0, 8'h0, 8'h38, 8'h2, 2'h0, 2'h0, 16'd16}, '{8'h0, 8'h0, 8'h48, 8'h2, 2'h0, 2'h0, 16'd20},
		'{8'h0, 8'h0, 8'h58, 8'h2, 2'h0, 2'h0, 16'd4}, '{8'h0, 8'h0, 8'h68, 8'h1, 2'h0, 2'h0, 16'd1},
		'{8'h0, 8'h0, 8'h68, 8'hff, 2'h0, 2'h0, 16'd255}, '{8'h0, 8'h0, 8'h08, 8'h2, 2'h1, 2'h0, 16'd160},
		'{8'h0, 8'h0, 8'h08, 8'h2, 2'h2, 2'h0, 16'd160}, '{8'h63, 8'h2, 8'h5c, 8'h1, 2'h0, 2'h0, 16'd258},
		'{8'h69, 8'h4, 8'h0, 8'h0, 2'h0, 2'h2, 16'd4}};
	dual_timer_counter DUT (.*);
	// ***************************************************************
	// clock, slow oscillator of period ten cycles, irq counters, timeout
	// ***************************************************************
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		slow_cnt <= (slow_cnt == 4) ? 0 : slow_cnt + 1;
		if (slow_cnt == 4) slow_osc <= !slow_osc;
		if (lower_match_irq === 1'b1) n_irq_l <= n_irq_l + 1;
		if (upper_match_irq === 1'b1) n_irq_u <= n_irq_u + 1;
		pin_prev <= lower_divider_out_pin_n;
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			final_report();
		end
	end
	// ***************************************************************
	// tasks
	// ***************************************************************
	task final_report;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_fail);
			if (n_fail == 0 && num_checks > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		begin
			num_checks++;
			if (got !== exp) begin
				n_fail++;
				$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// one apb transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int k;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h000000, d};
			pstrb <= s;
			@(posedge pclk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge pclk);
				k++;
			end while (pready !== 1'b1 && k < 20);
			if (k == 20) n_fail++;
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'h1, r, e);
	endtask
	function automatic logic hit(input logic [1:0] sel);
		return (sel == 2'h0) ? upper_match_irq : (sel == 2'h1) ? lower_match_irq : (lower_divider_out_pin_n != pin_prev);
	endfunction
	// cycles between the next two events on the watched output
	task automatic gap_of(input logic [1:0] sel, output logic [15:0] cnt);
		int k;
		begin
			k = 0;
			do begin
				@(posedge pclk);
				#1;
				k++;
			end while (hit(sel) !== 1'b1 && k < 6000);
			cnt = 16'h0000;
			do begin
				@(posedge pclk);
				#1;
				cnt++;
			end while (hit(sel) !== 1'b1 && cnt < 16'd6000);
		end
	endtask
	task pulses;
		repeat (6) begin
			lower_counter_input <= 1'b0;
			upper_counter_input <= 1'b0;
			repeat (8) @(posedge pclk);
			lower_counter_input <= 1'b1;
			upper_counter_input <= 1'b1;
			repeat (8) @(posedge pclk);
		end
	endtask
	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		{pclk, presetn, ce, psel, penable, pwrite, paddr, pwdata, pstrb, slow_osc} = '0;
		{lower_counter_input, upper_counter_input, n_fail, num_checks, cycles, slow_cnt, n_irq_l, n_irq_u} = '0;
		{lower_counter_input, upper_counter_input, ce, pin_prev, uc_now, lc_now} = {4'hf, 16'h0};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) begin
			apb(1'b1, regs[i].a, regs[i].d, regs[i].s, r, e);
			chk_word("write refusal", {31'h0, regs[i].we}, {31'h0, e});
			apb(1'b0, regs[i].a, 8'h00, 4'h0, r, e);
			chk_word("read data", regs[i].r, r);
			chk_word("read refusal", {31'h0, regs[i].re}, {31'h0, e});
		end
		$display("register test done");
		foreach (gaps[i]) begin
			wr(8'h6c, uc_now & 8'hf7);
			wr(8'h68, lc_now & 8'hf7);
			wr(8'h50, {6'h00, gaps[i].cfg});
			wr(8'h40, gaps[i].lv);
			wr(8'h44, gaps[i].uv);
			wr(8'h68, gaps[i].lc);
			wr(8'h6c, gaps[i].uc);
			uc_now = gaps[i].uc;
			lc_now = gaps[i].lc;
			gap_of(gaps[i].sel, n);
			chk_word("event spacing", {16'h0, gaps[i].gap}, {16'h0, n});
		end
		$display("clock select and mode test done");
		wr(8'h68, lc_now & 8'hf7);
		wr(8'h68, 8'h81);
		repeat (2) @(posedge pclk);
		#1 chk_word("lower pin set", 32'h0, {31'h0, lower_divider_out_pin_n});
		wr(8'h68, 8'h00);
		repeat (2) @(posedge pclk);
		#1 chk_word("lower pin clear", 32'h1, {31'h0, lower_divider_out_pin_n});
		wr(8'h6c, 8'h00);
		apb(1'b0, 8'h58, 8'h00, 4'h0, r, e);
		chk_word("stopped count", 32'h0, r);
		$display("flip-flop and stop test done");
		wr(8'h40, 8'h03);
		wr(8'h44, 8'h02);
		wr(8'h68, 8'h78);
		wr(8'h6c, 8'h78);
		il = n_irq_l;
		iu = n_irq_u;
		pulses();
		repeat (20) @(posedge pclk);
		chk_word("lower events", il + 2, n_irq_l);
		chk_word("upper events", iu + 3, n_irq_u);
		$display("event counter test done");
		wr(8'h6c, 8'h70);
		wr(8'h44, 8'h03);
		wr(8'h6c, 8'h68);
		gap_of(2'h0, n);
		chk_word("compare rewrite", 32'h3, {16'h0, n});
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		#1 chk_word("pins in reset", 32'h3, {30'h0, upper_divider_out_pin_n, lower_divider_out_pin_n});
		presetn <= 1'b1;
		apb(1'b0, 8'h6c, 8'h00, 4'h0, r, e);
		chk_word("upper control reset", 32'h0, r);
		apb(1'b0, 8'h44, 8'h00, 4'h0, r, e);
		chk_word("compare reset", 32'h0, r);
		$display("reset test done");
		final_report();
	end
endmodule // dual_timer_counter_tb_top
bind dual_timer_counter dual_timer_counter_properties chk (.*);
